// >>> acr_defs.vh
// ************************************************************
// Constants for the comparator and converter result control.
// ************************************************************
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ************************************************************
// Register offsets.
// ************************************************************
`define ACR_ADDR_W        3
`define ACR_OFS_CMP_CS    3'h0
`define ACR_OFS_SFIO      3'h1
`define ACR_OFS_CHSEL     3'h2
`define ACR_OFS_CONV_CTL  3'h3
`define ACR_OFS_RES_LO    3'h4
`define ACR_OFS_RES_HI    3'h5

// ************************************************************
// Field positions.
// ************************************************************
`define ACR_CS_POWER_OFF  7
`define ACR_CS_BANDGAP    6
`define ACR_CS_SYNC_OUT   5
`define ACR_CS_IRQ_FLAG   4
`define ACR_CS_IRQ_EN     3
`define ACR_CS_CAPTURE    2
`define ACR_CS_MODE_HI    1
`define ACR_CS_MODE_LO    0
`define ACR_SF_MUX_EN     3
`define ACR_CH_REF_HI     7
`define ACR_CH_REF_LO     6
`define ACR_CH_LEFT_ADJ   5
`define ACR_CC_ENABLE     7
`define ACR_CC_IRQ_EN     3
`define ACR_CC_DONE_FLAG  4

// ************************************************************
// Interrupt modes and reset values.
// ************************************************************
`define ACR_MODE_TOGGLE   2'h0
`define ACR_MODE_RESERVED 2'h1
`define ACR_MODE_FALL     2'h2
`define ACR_MODE_RISE     2'h3
`define ACR_RST_BYTE      8'h00
`define ACR_RST_RESULT    10'h000

`endif

// >>> acr_edge_detect.v
`timescale 1ns/1ps
`include "acr_defs.vh"
// ************************************************************
// Synchronizer and mode-selected edge detector.
// ************************************************************
module acr_edge_detect (
  input  wire       mclk_i,    // System clock.
  input  wire       rst_n_i,   // Asynchronous reset, active low.
  input  wire       raw_i,     // Raw comparator output.
  input  wire [1:0] mode_i,    // Interrupt mode select.
  output reg        sync_o,    // Synchronized output.
  output reg        event_o    // One-cycle selected event.
);

  reg meta;
  reg prev;

  // Two flops then history flop for edge comparison.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= raw_i;
      sync_o <= meta;
      prev   <= sync_o;
    end
  end

  // Mode decode of the edge.
  always @* begin
    case (mode_i)
      `ACR_MODE_TOGGLE: event_o = sync_o ^ prev;
      `ACR_MODE_FALL:   event_o = prev & ~sync_o;
      `ACR_MODE_RISE:   event_o = ~prev & sync_o;
      default:          event_o = 1'b0;
    endcase
  end

endmodule

// >>> acr_top.v
`timescale 1ns/1ps
`include "acr_defs.vh"
// ************************************************************
// Comparator control and converter result control.
// ************************************************************
module acr_top (
  input  wire                   mclk_i,          // System clock, 40 MHz.
  input  wire                   rst_n_i,         // Asynchronous reset, active low.
  input  wire [`ACR_ADDR_W-1:0] addr_i,          // Register address.
  input  wire [7:0]             wdata_i,         // Write data.
  input  wire                   wr_i,            // Write strobe.
  input  wire                   rd_i,            // Read strobe.
  output reg  [7:0]             rdata_o,         // Read data, cycle after strobe.
  input  wire                   cmp_raw_i,       // Raw analog comparator output.
  input  wire                   global_irq_en_i, // Global interrupt enable.
  input  wire                   cmp_vector_i,    // Comparator vector executed pulse.
  input  wire                   conv_done_i,     // Conversion complete pulse.
  input  wire [9:0]             conv_result_i,   // Raw converter result.
  input  wire                   done_vector_i,   // Completion vector executed pulse.
  output reg                    cmp_power_off_o, // Comparator power switched off.
  output reg                    cmp_pos_bg_o,    // Positive input is bandgap.
  output reg                    cmp_neg_mux_o,   // Negative input from channel mux.
  output reg  [7:0]             cmp_neg_pin_o,   // One-hot analog pin for negative input.
  output reg                    cmp_irq_o,       // Comparator interrupt request.
  output reg                    capture_in_o,    // Timer capture front-end input.
  output reg                    conv_en_o,       // Converter enabled.
  output reg  [4:0]             conv_channel_o,  // Applied channel and gain select.
  output reg  [1:0]             conv_ref_o,      // Applied reference select.
  output reg                    conv_irq_o       // Conversion-complete request.
);

  // ************************************************************
  // Registers.
  // ************************************************************
  reg       power_off;
  reg       bandgap_sel;
  reg       cmp_irq_flag;
  reg       cmp_irq_enable;
  reg       cmp_capture_route;
  reg [1:0] cmp_irq_mode;
  reg [7:0] special_function_io;
  reg [7:0] converter_channel_select_reg;
  reg [7:0] converter_control_reg;
  reg [9:0] result;
  reg       result_lock;
  wire      global_irq_en;
  wire      cmp_sync_output;
  wire      cmp_event;
  wire      cmp_mux_enable;
  wire      converter_enable;
  wire      left_adjust_result;
  wire [7:0] result_low_byte;
  wire [7:0] result_high_byte;
  wire [7:0] comparator_control_status;
  reg  [7:0] next_rdata;

  assign cmp_mux_enable     = special_function_io[`ACR_SF_MUX_EN];
  assign converter_enable   = converter_control_reg[`ACR_CC_ENABLE];
  assign left_adjust_result = converter_channel_select_reg[`ACR_CH_LEFT_ADJ];

  // Decodes one byte lane of the result for the justification.
  function [7:0] res_byte;
    input [9:0] value;
    input       left;
    input       high;
    begin
      if (left && high) begin
        res_byte = value[9:2];
      end else if (left) begin
        res_byte = {value[1:0], 6'h00};
      end else if (high) begin
        res_byte = {6'h00, value[9:8]};
      end else begin
        res_byte = value[7:0];
      end
    end
  endfunction

  assign result_low_byte  = res_byte(result, left_adjust_result, 1'b0);
  assign result_high_byte = res_byte(result, left_adjust_result, 1'b1);

  assign comparator_control_status = {power_off, bandgap_sel, cmp_sync_output,
                                      cmp_irq_flag, cmp_irq_enable, cmp_capture_route,
                                      cmp_irq_mode};

  // ************************************************************
  // Comparator synchronizer and edge detection.
  // ************************************************************
  acr_edge_detect u_edge (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (cmp_raw_i),
    .mode_i  (cmp_irq_mode),
    .sync_o  (cmp_sync_output),
    .event_o (cmp_event)
  );

  // Global enable comes from the core on this same clock, so it needs no synchronizer.
  assign global_irq_en = global_irq_en_i;

  // ************************************************************
  // Comparator control register and interrupt flag.
  // ************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_off         <= 1'b0;
      bandgap_sel       <= 1'b0;
      cmp_irq_flag      <= 1'b0;
      cmp_irq_enable    <= 1'b0;
      cmp_capture_route <= 1'b0;
      cmp_irq_mode      <= `ACR_MODE_TOGGLE;
    end else begin
      if (wr_i && addr_i == `ACR_OFS_CMP_CS) begin
        power_off         <= wdata_i[`ACR_CS_POWER_OFF];
        bandgap_sel       <= wdata_i[`ACR_CS_BANDGAP];
        cmp_irq_enable    <= wdata_i[`ACR_CS_IRQ_EN];
        cmp_capture_route <= wdata_i[`ACR_CS_CAPTURE];
        cmp_irq_mode      <= wdata_i[`ACR_CS_MODE_HI:`ACR_CS_MODE_LO];
      end
      // Set wins over a clear arriving in the same cycle.
      if (cmp_event) begin
        cmp_irq_flag <= 1'b1;
      end else if (cmp_vector_i) begin
        cmp_irq_flag <= 1'b0;
      end else if (wr_i && addr_i == `ACR_OFS_CMP_CS && wdata_i[`ACR_CS_IRQ_FLAG]) begin
        cmp_irq_flag <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Special function, channel select and converter control.
  // ************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      special_function_io          <= `ACR_RST_BYTE;
      converter_channel_select_reg <= `ACR_RST_BYTE;
      converter_control_reg        <= `ACR_RST_BYTE;
    end else begin
      if (wr_i && addr_i == `ACR_OFS_SFIO) begin
        special_function_io <= wdata_i;
      end
      if (wr_i && addr_i == `ACR_OFS_CHSEL) begin
        converter_channel_select_reg <= wdata_i;
      end
      // Completion flag: set wins, write one or vector clears.
      if (conv_done_i) begin
        converter_control_reg[`ACR_CC_DONE_FLAG] <= 1'b1;
      end else if (done_vector_i) begin
        converter_control_reg[`ACR_CC_DONE_FLAG] <= 1'b0;
      end else if (wr_i && addr_i == `ACR_OFS_CONV_CTL && wdata_i[`ACR_CC_DONE_FLAG]) begin
        converter_control_reg[`ACR_CC_DONE_FLAG] <= 1'b0;
      end
      if (wr_i && addr_i == `ACR_OFS_CONV_CTL) begin
        converter_control_reg[7:5] <= wdata_i[7:5];
        converter_control_reg[3:0] <= wdata_i[3:0];
      end
    end
  end

  // ************************************************************
  // Result registers and read lock.
  // ************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result      <= `ACR_RST_RESULT;
      result_lock <= 1'b0;
    end else begin
      if (conv_done_i && !result_lock) begin
        result <= conv_result_i;
      end
      if (rd_i && addr_i == `ACR_OFS_RES_HI) begin
        result_lock <= 1'b0;
      end else if (rd_i && addr_i == `ACR_OFS_RES_LO) begin
        result_lock <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Read data, valid in the cycle after the strobe.
  // ************************************************************
  always @* begin
    if (addr_i == `ACR_OFS_CMP_CS) begin
      next_rdata = comparator_control_status;
    end else if (addr_i == `ACR_OFS_SFIO) begin
      next_rdata = special_function_io;
    end else if (addr_i == `ACR_OFS_CHSEL) begin
      next_rdata = converter_channel_select_reg;
    end else if (addr_i == `ACR_OFS_CONV_CTL) begin
      next_rdata = converter_control_reg;
    end else if (addr_i == `ACR_OFS_RES_LO) begin
      next_rdata = result_low_byte;
    end else if (addr_i == `ACR_OFS_RES_HI) begin
      next_rdata = result_high_byte;
    end else begin
      next_rdata = `ACR_RST_BYTE;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= `ACR_RST_BYTE;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `ACR_RST_BYTE;
    end
  end

  // ************************************************************
  // Registered analog and interrupt controls.
  // ************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_power_off_o <= 1'b0;
      cmp_pos_bg_o    <= 1'b0;
      cmp_neg_mux_o   <= 1'b0;
      cmp_neg_pin_o   <= 8'h00;
      cmp_irq_o       <= 1'b0;
      capture_in_o    <= 1'b0;
      conv_en_o       <= 1'b0;
      conv_channel_o  <= 5'h00;
      conv_ref_o      <= 2'h0;
      conv_irq_o      <= 1'b0;
    end else begin
      cmp_power_off_o <= power_off;
      cmp_pos_bg_o    <= bandgap_sel;
      cmp_neg_mux_o   <= cmp_mux_enable && !converter_enable;
      if (cmp_mux_enable && !converter_enable) begin
        cmp_neg_pin_o <= 8'h01 << converter_channel_select_reg[2:0];
      end else begin
        cmp_neg_pin_o <= 8'h00;
      end
      cmp_irq_o       <= cmp_irq_flag && cmp_irq_enable && global_irq_en;
      capture_in_o    <= cmp_capture_route & cmp_sync_output;
      conv_en_o       <= converter_enable;
      if (converter_enable) begin
        conv_channel_o <= converter_channel_select_reg[4:0];
        conv_ref_o     <= converter_channel_select_reg[`ACR_CH_REF_HI:`ACR_CH_REF_LO];
      end
      conv_irq_o <= converter_control_reg[`ACR_CC_DONE_FLAG] &&
                    converter_control_reg[`ACR_CC_IRQ_EN] && global_irq_en;
    end
  end

endmodule

// >>> acr_analog_model.sv
`timescale 1ns/1ps
// ************************************************
// Analog side: comparator, converter, timer capture.
// ************************************************
module acr_analog_model (
  input  wire       mclk_i,   // Clock.
  input  wire       rst_n_i,  // Reset, active low.
  input  wire       level_i,  // Comparator level.
  input  wire       start_i,  // Start a conversion.
  input  wire [9:0] value_i,  // Sample to convert.
  input  wire [7:0] delay_i,  // Conversion length.
  input  wire       cap_i,    // Capture input.
  input  wire       mask_i,   // Capture irq mask.
  output reg        raw_o,    // Comparator output.
  output reg        done_o,   // Done pulse.
  output reg  [9:0] result_o, // Result lines.
  output reg  [7:0] caps_o    // Captures seen.
);
  reg [7:0] cnt;
  reg       cap_q;

  // Result lines wobble outside the done cycle, so a stale value never passes.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= 10'h000;
      caps_o <= 8'h00;
      cnt <= 8'h00;
      cap_q <= 1'b0;
    end else begin
      raw_o <= level_i;
      cap_q <= cap_i;
      done_o <= cnt == 8'h01;
      result_o <= (cnt == 8'h01) ? value_i : ~result_o;
      cnt <= start_i ? delay_i : ((cnt != 8'h00) ? cnt - 8'h01 : cnt);
      if (mask_i && cap_i && !cap_q) begin
        caps_o <= caps_o + 8'h01;
      end
    end
  end
endmodule

// >>> acr_top_assertions.sv
`timescale 1ns/1ps
// ************************************************
// Port checks of comparator and converter control.
// ************************************************
module acr_top_assertions (
  input wire       mclk_i,          // Clock.
  input wire       rst_n_i,         // Reset.
  input wire [2:0] addr_i,          // Address.
  input wire [7:0] wdata_i,         // Write data.
  input wire       wr_i,            // Write strobe.
  input wire       cmp_raw_i,       // Raw output.
  input wire       global_irq_en_i, // Global enable.
  input wire       cmp_power_off_o, // Power off.
  input wire       cmp_pos_bg_o,    // Bandgap.
  input wire       cmp_neg_mux_o,   // Mux input.
  input wire [7:0] cmp_neg_pin_o,   // Pin select.
  input wire       cmp_irq_o,       // Request.
  input wire       capture_in_o,    // Capture.
  input wire       conv_en_o,       // Converter on.
  input wire [4:0] conv_channel_o,  // Channel.
  input wire [1:0] conv_ref_o       // Reference.
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Writes whose effect reaches the outputs two edges later.
  sequence s_cs_wr;
    wr_i && addr_i == 3'h0;
  endsequence
  sequence s_mux_off;
    wr_i && addr_i == 3'h1 && !wdata_i[3];
  endsequence
  sequence s_cc_wr;
    wr_i && addr_i == 3'h3;
  endsequence

  a_cs_write_out: assert property (s_cs_wr |-> ##2
    cmp_power_off_o == $past(wdata_i[7], 2) && cmp_pos_bg_o == $past(wdata_i[6], 2))
    else $error("power or bandgap output wrong");
  a_mux_write_off: assert property (s_mux_off |-> ##2 !cmp_neg_mux_o)
    else $error("mux input kept after disable");
  a_conv_enable: assert property (s_cc_wr |-> ##2 conv_en_o == $past(wdata_i[7], 2))
    else $error("converter enable wrong");
  a_sel_held: assert property (!conv_en_o && !$past(conv_en_o) |->
    $stable(conv_channel_o) && $stable(conv_ref_o)) else $error("selection moved while off");
  a_neg_pin_sel: assert property (cmp_neg_mux_o ? $onehot(cmp_neg_pin_o)
    : cmp_neg_pin_o == 8'h00) else $error("negative pin select wrong");
  a_mux_conv_on: assert property (conv_en_o [*3] |-> !cmp_neg_mux_o)
    else $error("mux borrowed while converter on");
  a_irq_gated: assert property (!global_irq_en_i [*5] |-> !cmp_irq_o)
    else $error("request without global enable");
  a_capture_lag: assert property (capture_in_o |-> $past(cmp_raw_i, 3))
    else $error("capture input not from comparator");
endmodule

bind acr_top acr_top_assertions i_acr_top_assertions (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .cmp_raw_i(cmp_raw_i), .global_irq_en_i(global_irq_en_i),
  .cmp_power_off_o(cmp_power_off_o), .cmp_pos_bg_o(cmp_pos_bg_o),
  .cmp_neg_mux_o(cmp_neg_mux_o), .cmp_neg_pin_o(cmp_neg_pin_o), .cmp_irq_o(cmp_irq_o),
  .capture_in_o(capture_in_o), .conv_en_o(conv_en_o), .conv_channel_o(conv_channel_o),
  .conv_ref_o(conv_ref_o));

// >>> acr_top_tb_top.sv
`timescale 1ns/1ps
module acr_top_tb_top;
  // ************************************************
  // Stimulus, partner and design.
  // ************************************************
  reg        mclk_i = 1'b0;
  reg        rst_n_i = 1'b0;
  reg  [2:0] addr_i = 3'h0;
  reg  [7:0] wdata_i = 8'h00;
  reg        wr_i = 1'b0;
  reg        rd_i = 1'b0;
  reg        global_irq_en_i = 1'b0;
  reg        cmp_vector_i = 1'b0;
  reg        done_vector_i = 1'b0;
  reg        lvl = 1'b0;
  reg        start = 1'b0;
  reg  [9:0] value = 10'h000;
  reg  [7:0] delay = 8'h02;
  reg        rd_d = 1'b0;
  reg  [7:0] v, ex;
  reg  [9:0] r1, r2;
  integer    i, m, e, k;
  integer    mismatches = 0;
  integer    n_checks = 0;
  reg  [7:0] expq[$];
  wire [7:0] rdata_o, cmp_neg_pin_o, caps;
  wire [9:0] conv_result_i;
  wire [4:0] conv_channel_o;
  wire [1:0] conv_ref_o;
  wire       cmp_raw_i, conv_done_i, cmp_power_off_o, cmp_pos_bg_o, cmp_neg_mux_o;
  wire       cmp_irq_o, capture_in_o, conv_en_o, conv_irq_o;

  always #12.5 mclk_i = ~mclk_i;

  acr_top i_acr_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_raw_i(cmp_raw_i),
    .global_irq_en_i(global_irq_en_i), .cmp_vector_i(cmp_vector_i),
    .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .done_vector_i(done_vector_i),
    .cmp_power_off_o(cmp_power_off_o), .cmp_pos_bg_o(cmp_pos_bg_o),
    .cmp_neg_mux_o(cmp_neg_mux_o), .cmp_neg_pin_o(cmp_neg_pin_o), .cmp_irq_o(cmp_irq_o),
    .capture_in_o(capture_in_o), .conv_en_o(conv_en_o), .conv_channel_o(conv_channel_o),
    .conv_ref_o(conv_ref_o), .conv_irq_o(conv_irq_o));
  acr_analog_model i_acr_analog_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .level_i(lvl),
    .start_i(start), .value_i(value), .delay_i(delay), .cap_i(capture_in_o), .mask_i(1'b1),
    .raw_o(cmp_raw_i), .done_o(conv_done_i), .result_o(conv_result_i), .caps_o(caps));

  // ************************************************
  // Bus tasks and comparison.
  // ************************************************
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge mclk_i);
    end
  endtask
  // A read notes its expected byte; the watcher below compares it.
  task rd(input [2:0] a, input [7:0] x);
    begin
      expq.push_back(x);
      addr_i <= a;
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      @(posedge mclk_i);
    end
  endtask
  task idle(input integer n);
    begin
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n) @(posedge mclk_i);
    end
  endtask
  // Runs one conversion of random length, so the partner answers fast and slow.
  task conv(input [9:0] x);
    begin
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      value <= x;
      delay <= 8'(2 + $urandom % 12);
      start <= 1'b1;
      @(posedge mclk_i);
      start <= 1'b0;
      k = 0;
      while (!conv_done_i && k < 40) begin
        @(posedge mclk_i);
        k = k + 1;
      end
      idle(3);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask

  // Read data stand in the cycle after the strobe only.
  always @(posedge mclk_i) rd_d <= rd_i;
  always @(negedge mclk_i) begin
    if (rd_d && expq.size() > 0) chk("rdata", rdata_o, expq.pop_front());
  end

  // Cuts a hang short, far beyond the few hundred cycles the run needs.
  initial begin
    #200000;
    mismatches = mismatches + 1;
    summarize();
  end

  // ************************************************
  // Scenarios.
  // ************************************************
  initial begin
    void'($urandom(86473));
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    for (i = 0; i < 8; i = i + 1) rd(i[2:0], 8'h00);
    wr(3'h0, 8'hC7);
    idle(2);
    chk("power", {cmp_power_off_o, cmp_pos_bg_o}, 8'h03);
    rd(3'h0, 8'hC7);
    for (m = 0; m < 4; m = m + 1) begin
      for (e = 0; e < 2; e = e + 1) begin
        wr(3'h0, 8'h10 | m[7:0]);
        lvl <= (e == 0);
        idle(8);
        ex = {2'b00, e == 0, m == 0 || (m == 3 && e == 0) || (m == 2 && e == 1), 2'b00, m[1:0]};
        rd(3'h0, ex);
      end
    end
    global_irq_en_i <= 1'b1;
    wr(3'h0, 8'h13);
    wr(3'h0, 8'h0B);
    lvl <= 1'b1;
    idle(8);
    chk("cmp_irq", 8'(cmp_irq_o), 8'h01);
    cmp_vector_i <= 1'b1;
    idle(1);
    cmp_vector_i <= 1'b0;
    idle(3);
    chk("cmp_irq", 8'(cmp_irq_o), 8'h00);
    lvl <= 1'b0;
    global_irq_en_i <= 1'b0;
    idle(6);
    lvl <= 1'b1;
    idle(8);
    chk("cmp_irq", 8'(cmp_irq_o), 8'h00);
    wr(3'h0, 8'h03);
    rd(3'h0, 8'h33);
    wr(3'h0, 8'h13);
    rd(3'h0, 8'h23);
    lvl <= 1'b0;
    idle(6);
    wr(3'h0, 8'h04);
    for (i = 0; i < 4; i = i + 1) begin
      if (i == 3) wr(3'h0, 8'h00);
      lvl <= 1'b1;
      idle(6);
      lvl <= 1'b0;
      idle(6);
    end
    chk("captures", caps, 8'h03);
    v = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      ex = v;
      v = $urandom;
      v[5] = 1'b0;
      v[2:0] = i[2:0];
      wr(3'h3, 8'h00);
      wr(3'h2, v);
      wr(3'h1, 8'h08);
      idle(3);
      chk("neg_pin", cmp_neg_pin_o, 8'h01 << i);
      chk("neg_mux", 8'(cmp_neg_mux_o), 8'h01);
      chk("held_sel", {conv_ref_o, 1'b0, conv_channel_o}, ex);
      wr(3'h1, 8'h00);
      idle(3);
      chk("neg_mux", 8'(cmp_neg_mux_o), 8'h00);
      chk("neg_pin", cmp_neg_pin_o, 8'h00);
      wr(3'h1, 8'h08);
      wr(3'h3, 8'h80);
      idle(3);
      chk("neg_pin", cmp_neg_pin_o, 8'h00);
      chk("conv_sel", {conv_en_o, conv_ref_o, conv_channel_o}, {1'b1, v[7:6], v[4:0]});
    end
    global_irq_en_i <= 1'b1;
    wr(3'h3, 8'h98);
    for (m = 0; m < 2; m = m + 1) begin
      wr(3'h2, {2'b00, m[0], 5'h00});
      r1 = $urandom;
      r2 = m ? 10'h3FF : $urandom;
      conv(r1);
      rd(3'h4, m ? {r1[1:0], 6'h00} : r1[7:0]);
      wr(3'h3, 8'h98);
      conv(r2);
      chk("done_irq", 8'(conv_irq_o), 8'h01);
      rd(3'h5, m ? r1[9:2] : {6'h00, r1[9:8]});
      if (m) begin
        done_vector_i <= 1'b1;
        idle(1);
        done_vector_i <= 1'b0;
      end else begin
        wr(3'h3, 8'h98);
      end
      idle(3);
      chk("done_irq", 8'(conv_irq_o), 8'h00);
      conv(r2);
      rd(3'h4, m ? {r2[1:0], 6'h00} : r2[7:0]);
      rd(3'h5, m ? r2[9:2] : {6'h00, r2[9:8]});
    end
    idle(4);
    summarize();
  end
endmodule
